// ---- inc/cai_pkg.sv ----
package cai_pkg;

    // ----------------------------------------------------------------
    // Opcode fields
    // ----------------------------------------------------------------
    localparam logic [3:0] OPC_AREG_CMP = 4'hb;
    localparam logic [7:0] OPC_IMM_CMP = 8'h0c;
    localparam logic [2:0] OPMODE_WORD = 3'h3;
    localparam logic [2:0] OPMODE_LONG = 3'h7;
    localparam int OPW_AREG_HI = 11;
    localparam int OPW_AREG_LO = 9;
    localparam int OPW_OPMODE_HI = 8;
    localparam int OPW_OPMODE_LO = 6;
    localparam int OPW_SIZE_HI = 7;
    localparam int OPW_SIZE_LO = 6;
    localparam int OPW_EAMODE_HI = 5;
    localparam int OPW_EAMODE_LO = 3;
    localparam int OPW_EAREG_HI = 2;
    localparam int OPW_EAREG_LO = 0;

    // ----------------------------------------------------------------
    // Effective address codes
    // ----------------------------------------------------------------
    localparam logic [2:0] EA_MODE_AREG = 3'h1;
    localparam logic [2:0] EA_MODE_EXT = 3'h7;
    localparam logic [2:0] EA_EXT_PCIDX = 3'h3;
    localparam logic [2:0] EA_EXT_IMM = 3'h4;

    // ----------------------------------------------------------------
    // Register map and fields
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_AREG_BASE = 8'h00;
    localparam logic [7:0] REG_CCR = 8'h20;
    localparam logic [7:0] REG_DIFF = 8'h24;
    localparam logic [7:0] REG_STAT = 8'h28;
    localparam logic [7:0] REG_CTRL = 8'h2c;
    localparam int CC_X = 4;
    localparam int CC_N = 3;
    localparam int CC_Z = 2;
    localparam int CC_V = 1;
    localparam int CC_C = 0;
    localparam int ST_BUSY = 0;
    localparam int ST_ILLEGAL = 1;
    localparam int ST_KIND_IMM = 2;
    localparam int CTRL_ENABLE = 0;
    localparam logic [4:0] CCR_RST = 5'h00;
    localparam logic CTRL_ENABLE_RST = 1'b1;
    localparam logic [31:0] AREG_RST = 32'h0000_0000;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0]
    {
        SZ_BYTE = 2'b00,
        SZ_WORD = 2'b01,
        SZ_LONG = 2'b10,
        SZ_BAD = 2'b11
    } cai_size_type;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b000,
        ST_IMM = 3'b001,
        ST_OPER = 3'b010,
        ST_EXEC = 3'b011
    } cai_state_type;

    typedef struct packed
    {
        logic [2:0] mode;
        logic [2:0] rsel;
        cai_size_type size;
    } cai_ea_type;

    typedef struct packed
    {
        logic n;
        logic z;
        logic v;
        logic c;
    } cai_nzvc_type;

endpackage

// ---- sim/cai_compare_exec_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module cai_compare_exec_bench;
    import cai_pkg::*;
    logic clk_sys = 0;
    logic reset = 1;
    logic op_valid = 0, ext_valid = 0, ea_valid = 0, reg_wr = 0, reg_rd = 0;
    logic op_ready, ext_ready, ea_req, done, illegal, xb;
    logic [15:0] op_word = 0, ext_word = 0;
    logic [31:0] ea_data = 0, reg_wdata = 0, reg_rdata;
    logic [7:0] reg_addr = 0;
    logic [4:0] ccr;
    cai_ea_type ea_spec;
    logic [31:0] areg [8];
    logic [5:0] am [4] = '{6'h00, 6'h09, 6'h3c, 6'h3a};
    logic [5:0] im_m [4] = '{6'h00, 6'h12, 6'h3b, 6'h38};
    logic [15:0] bad_ops [6] = '{16'h0c48, 16'h0cc0, 16'h0c3c, 16'hb040,
        16'hb1fd, 16'h4e71};
    int n_fail = 0, n_tests = 0;

    cai_compare_exec uut (.clk_sys(clk_sys), .reset(reset),
        .op_valid(op_valid), .op_word(op_word), .op_ready(op_ready),
        .ext_valid(ext_valid), .ext_word(ext_word), .ext_ready(ext_ready),
        .ea_req(ea_req), .ea_spec(ea_spec), .ea_valid(ea_valid),
        .ea_data(ea_data), .done(done), .illegal(illegal), .ccr(ccr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    // Core clock, 4 ns period.
    always #2 clk_sys = ~clk_sys;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Bounded wait, sampled at the falling edge so values have settled.
    task automatic wait_for(input int k);
        logic s;
        for (int i = 0; i < 20; i++)
        begin
            @(negedge clk_sys);
            s = (k == 0) ? op_ready : (k == 1) ? ext_ready :
                (k == 2) ? ea_req : (done | illegal);
            if (s === 1'b1)
                return;
        end
        n_fail++;
        close_out();
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        reg_rd <= 1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 0;
        @(negedge clk_sys);
        chk(reg_rdata, exp);
    endtask

    // Reference flags of dst minus src at b bits.
    function automatic logic [3:0] nzvc(logic [31:0] d, logic [31:0] s,
        int b);
        logic [31:0] m, r;
        m = (b == 32) ? '1 : (32'h1 << b) - 1;
        r = (d - s) & m;
        return {r[b-1], r == 0, d[b-1] != s[b-1] && r[b-1] != d[b-1],
            (s & m) > (d & m)};
    endfunction

    task automatic run(input logic [15:0] op, input logic [31:0] imm,
        input logic [31:0] ed, input logic [31:0] dst,
        input logic [31:0] src, input int b);
        logic [1:0] sz;
        int nw;
        sz = (op[15:12] == 4'hb) ? {op[8], ~op[8]} : op[7:6];
        nw = (op[15:12] == 4'hb) ? 0 : (b == 32) ? 2 : 1;
        @(posedge clk_sys);
        op_valid <= 1;
        op_word <= op;
        wait_for(0);
        @(posedge clk_sys);
        op_valid <= 0;
        for (int i = nw; i > 0; i--)
        begin
            ext_valid <= 1;
            ext_word <= (i == 2) ? imm[31:16] : imm[15:0];
            wait_for(1);
            @(posedge clk_sys);
            if (i == 1)
            begin
                ext_valid <= 0;
                ext_word <= ~imm[15:0];
            end
        end
        ea_valid <= 1;
        ea_data <= ed;
        wait_for(2);
        chk(ea_spec, {op[5:0], sz});
        @(posedge clk_sys);
        ea_valid <= 0;
        ea_data <= ~ed;
        wait_for(3);
        chk(done, 1);
        chk(ccr, {xb, nzvc(dst, src, b)});
    endtask

    task automatic bad(input logic [15:0] op);
        @(posedge clk_sys);
        op_valid <= 1;
        op_word <= op;
        wait_for(0);
        @(posedge clk_sys);
        op_valid <= 0;
        wait_for(3);
        chk(illegal, 1);
    endtask

    // Main sequence: reset, register file, both compares, refusals.
    initial
    begin
        logic [31:0] e, im;
        int n, b;
        xb = 0;
        void'($urandom(32'h47be));
        repeat (5) @(posedge clk_sys);
        reset <= 0;
        rd(REG_CCR, 0);
        rd(REG_CTRL, 1);
        wr(REG_CTRL, 0);
        @(negedge clk_sys);
        chk(op_ready, 0);
        wr(REG_CTRL, 1);
        for (n = 0; n < 8; n++)
        begin
            areg[n] = $urandom;
            wr(REG_AREG_BASE + 8'(4 * n), areg[n]);
        end
        for (int i = 0; i < 24; i++)
        begin
            n = $urandom % 8;
            xb = 1'($urandom);
            wr(REG_CCR, {27'h0, xb, 4'h0});
            e = (i % 4 == 0) ? areg[n] : $urandom;
            im = i[0] ? {{16{e[15]}}, e[15:0]} : e;
            run({4'hb, n[2:0], i[0] ? OPMODE_WORD : OPMODE_LONG, am[i % 4]},
                0, e, areg[n], im, 32);
            rd(REG_DIFF, areg[n] - im);
            rd(REG_AREG_BASE + 8'(4 * n), areg[n]);
        end
        for (int i = 0; i < 24; i++)
        begin
            b = 8 << (i % 3);
            xb = 1'($urandom);
            wr(REG_CCR, {27'h0, xb, 4'hf});
            im = $urandom;
            e = (i % 4 == 0) ? im : $urandom;
            run({8'h0c, 2'(i % 3), im_m[i % 4]}, im, e, e, im, b);
        end
        run({8'h0c, 2'b10, 6'h00}, 1, 32'h80000000, 32'h80000000, 1, 32);
        rd(REG_DIFF, 32'h7fff_ffff);
        rd(REG_STAT, 32'h0000_0004);
        foreach (bad_ops[k])
            bad(bad_ops[k]);
        rd(REG_STAT, 32'h0000_0006);
        close_out();
    end
endmodule
`default_nettype wire

// ---- verilog/cai_compare_exec.sv ----
`timescale 1ns/1ps
`default_nettype none
module cai_compare_exec
#(
    parameter int NUM_AREG = 8
)
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic op_valid,
    input wire logic [15:0] op_word,
    output logic op_ready,
    input wire logic ext_valid,
    input wire logic [15:0] ext_word,
    output logic ext_ready,
    output logic ea_req,
    output cai_pkg::cai_ea_type ea_spec,
    input wire logic ea_valid,
    input wire logic [31:0] ea_data,
    output logic done,
    output logic illegal,
    output logic [4:0] ccr,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata
);
    import cai_pkg::*;

    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    if (NUM_AREG != 8)
    begin : g_bad_areg
        $error("NUM_AREG must be 8 for a three-bit register field");
    end

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    cai_state_type state_r;
    logic [NUM_AREG-1:0][31:0] areg_r;
    logic [4:0] ccr_r;
    logic [31:0] diff_r;
    logic enable_r;
    logic kind_imm_r;
    logic illegal_r;
    logic done_r;
    logic last_illegal_r;
    logic [2:0] dst_idx_r;
    cai_ea_type ea_r;
    logic [31:0] imm_r;
    logic [1:0] ext_cnt_r;
    logic [1:0] ext_need;
    logic [31:0] cmp_dst;
    logic [31:0] cmp_src;
    logic [31:0] fu_diff;
    cai_nzvc_type fu_flags;
    cai_size_type op_size;
    logic [2:0] op_mode;
    logic [2:0] op_rsel;
    logic [2:0] op_opmode;
    logic accept;
    logic is_areg_cmp;
    logic is_imm_cmp;
    logic areg_ea_ok;
    logic imm_ea_ok;
    logic areg_ok;
    logic imm_ok;
    logic ext_last;
    logic exec_now;
    logic areg_sel;
    logic [31:0] rdata_nxt;
    logic [31:0] rdata_r;

    // ----------------------------------------------------------------
    // Opcode decode
    // ----------------------------------------------------------------
    // Field slices of the offered opcode word.
    assign op_mode = op_word[OPW_EAMODE_HI:OPW_EAMODE_LO];
    assign op_rsel = op_word[OPW_EAREG_HI:OPW_EAREG_LO];
    assign op_opmode = op_word[OPW_OPMODE_HI:OPW_OPMODE_LO];
    assign op_size = cai_size_type'(op_word[OPW_SIZE_HI:OPW_SIZE_LO]);
    assign accept = op_valid && op_ready;

    // Recognise the two compare encodings.
    assign is_areg_cmp = (op_word[15:12] == OPC_AREG_CMP);
    assign is_imm_cmp = (op_word[15:8] == OPC_IMM_CMP);

    // Every source mode is taken; only unused extended codes are refused.
    assign areg_ea_ok = (op_mode != EA_MODE_EXT) ||
                        (op_rsel <= EA_EXT_IMM);

    // Data modes without immediate and without address register direct.
    assign imm_ea_ok = (op_mode != EA_MODE_AREG) &&
                       ((op_mode != EA_MODE_EXT) ||
                        (op_rsel <= EA_EXT_PCIDX));

    // Only the word and long opmodes belong to the address compare.
    assign areg_ok = is_areg_cmp && areg_ea_ok &&
                     ((op_opmode == OPMODE_WORD) ||
                      (op_opmode == OPMODE_LONG));

    // The size code 11 is not an operation size.
    assign imm_ok = is_imm_cmp && imm_ea_ok && (op_size != SZ_BAD);

    // Long immediates take two extension words, others one.
    assign ext_need = (ea_r.size == SZ_LONG) ? 2'd2 : 2'd1;
    assign ext_last = ext_valid && (ext_cnt_r == ext_need - 2'd1);
    assign exec_now = (state_r == ST_EXEC);

    // ----------------------------------------------------------------
    // Handshake outputs
    // ----------------------------------------------------------------
    // New opcodes are taken only while idle and enabled.
    assign op_ready = (state_r == ST_IDLE) && enable_r;
    assign ext_ready = (state_r == ST_IMM);
    assign ea_req = (state_r == ST_OPER);
    assign ea_spec = ea_r;
    assign done = done_r;
    assign illegal = illegal_r;
    assign ccr = ccr_r;
    assign reg_rdata = rdata_r;

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    // Walks decode, extension fetch, operand fetch and execute.
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            state_r <= ST_IDLE;
        end
        else
        begin
            case (state_r)
                ST_IDLE:
                begin
                    if (accept && areg_ok)
                    begin
                        state_r <= ST_OPER;
                    end
                    else if (accept && imm_ok)
                    begin
                        state_r <= ST_IMM;
                    end
                end
                ST_IMM:
                begin
                    if (ext_last)
                    begin
                        state_r <= ST_OPER;
                    end
                end
                ST_OPER:
                begin
                    if (ea_valid)
                    begin
                        state_r <= ST_EXEC;
                    end
                end
                ST_EXEC:
                begin
                    state_r <= ST_IDLE;
                end
                default:
                begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Latches the decoded fields when a legal compare opcode is taken.
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            kind_imm_r <= 1'b0;
            dst_idx_r <= 3'h0;
            ea_r <= '{3'h0, 3'h0, SZ_LONG};
        end
        else if (accept && (areg_ok || imm_ok))
        begin
            kind_imm_r <= imm_ok;
            dst_idx_r <= op_word[OPW_AREG_HI:OPW_AREG_LO];
            ea_r.mode <= op_mode;
            ea_r.rsel <= op_rsel;
            if (imm_ok)
            begin
                ea_r.size <= op_size;
            end
            else if (op_opmode == OPMODE_WORD)
            begin
                ea_r.size <= SZ_WORD;
            end
            else
            begin
                ea_r.size <= SZ_LONG;
            end
        end
    end

    // Gathers the immediate from the extension words, high word first.
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            imm_r <= 32'h0000_0000;
            ext_cnt_r <= 2'd0;
        end
        else if (accept)
        begin
            ext_cnt_r <= 2'd0;
        end
        else if ((state_r == ST_IMM) && ext_valid)
        begin
            ext_cnt_r <= ext_cnt_r + 2'd1;
            case (ea_r.size)
                SZ_BYTE:
                begin
                    imm_r <= {24'h00_0000, ext_word[7:0]};
                end
                SZ_WORD:
                begin
                    imm_r <= {16'h0000, ext_word};
                end
                default:
                begin
                    imm_r <= {imm_r[15:0], ext_word};
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Operand routing and flag unit
    // ----------------------------------------------------------------
    // Address compare: register minus operand; immediate: operand minus immediate.
    always_comb
    begin
        if (kind_imm_r)
        begin
            cmp_dst = ea_data;
            cmp_src = imm_r;
        end
        else
        begin
            cmp_dst = areg_r[dst_idx_r];
            if (ea_r.size == SZ_WORD)
            begin
                cmp_src = {{16{ea_data[15]}}, ea_data[15:0]};
            end
            else
            begin
                cmp_src = ea_data;
            end
        end
    end

    // Address compares are always judged on all 32 bits.
    cai_flag_unit u_flags
    (
        .dst(cmp_dst),
        .src(cmp_src),
        .size(kind_imm_r ? ea_r.size : SZ_LONG),
        .diff(fu_diff),
        .flags(fu_flags)
    );

    // Operands are held in a register for the reference checks; the subtract uses the unregistered cmp_dst and cmp_src.
    logic [31:0] op_dst_r;
    logic [31:0] op_src_r;
    cai_size_type op_sz_r;
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            op_dst_r <= 32'h0000_0000;
            op_src_r <= 32'h0000_0000;
            op_sz_r <= SZ_LONG;
        end
        else if ((state_r == ST_OPER) && ea_valid)
        begin
            op_dst_r <= cmp_dst;
            op_src_r <= cmp_src;
            op_sz_r <= kind_imm_r ? ea_r.size : SZ_LONG;
        end
    end

    // Result registers: flags and difference; hardware wins over software.
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            ccr_r <= CCR_RST;
            diff_r <= 32'h0000_0000;
        end
        else
        begin
            if (reg_wr && (reg_addr == REG_CCR))
            begin
                ccr_r <= reg_wdata[4:0];
            end
            if ((state_r == ST_OPER) && ea_valid)
            begin
                // The extend flag is left as it is.
                ccr_r[CC_N] <= fu_flags.n;
                ccr_r[CC_Z] <= fu_flags.z;
                ccr_r[CC_V] <= fu_flags.v;
                ccr_r[CC_C] <= fu_flags.c;
                diff_r <= fu_diff;
            end
        end
    end

    // Completion and refusal pulses, plus the last-refusal bit that each taken opcode rewrites.
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            done_r <= 1'b0;
            illegal_r <= 1'b0;
            last_illegal_r <= 1'b0;
        end
        else
        begin
            done_r <= exec_now;
            illegal_r <= accept && !areg_ok && !imm_ok;
            if (accept)
            begin
                last_illegal_r <= !areg_ok && !imm_ok;
            end
        end
    end

    // ----------------------------------------------------------------
    // Register port
    // ----------------------------------------------------------------
    assign areg_sel = (reg_addr[7:5] == REG_AREG_BASE[7:5]) &&
                      (reg_addr[1:0] == 2'b00);

    // Address registers change only by software; compares never write.
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            areg_r <= {NUM_AREG{AREG_RST}};
            enable_r <= CTRL_ENABLE_RST;
        end
        else if (reg_wr)
        begin
            if (areg_sel)
            begin
                areg_r[reg_addr[4:2]] <= reg_wdata;
            end
            if (reg_addr == REG_CTRL)
            begin
                enable_r <= reg_wdata[CTRL_ENABLE];
            end
        end
    end

    // Read mux; unmapped addresses read as zero.
    always_comb
    begin
        rdata_nxt = 32'h0000_0000;
        if (areg_sel)
        begin
            rdata_nxt = areg_r[reg_addr[4:2]];
        end
        else
        begin
            case (reg_addr)
                REG_CCR: rdata_nxt = {27'h000_0000, ccr_r};
                REG_DIFF: rdata_nxt = diff_r;
                REG_STAT:
                begin
                    rdata_nxt[ST_BUSY] = (state_r != ST_IDLE);
                    rdata_nxt[ST_ILLEGAL] = last_illegal_r;
                    rdata_nxt[ST_KIND_IMM] = kind_imm_r;
                end
                REG_CTRL: rdata_nxt[CTRL_ENABLE] = enable_r;
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    // Read data stands only in the cycle after the strobe.
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            rdata_r <= 32'h0000_0000;
        end
        else
        begin
            rdata_r <= reg_rd ? rdata_nxt : 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_areg_hold;
        @(posedge clk_sys) disable iff (reset)
        ((state_r == ST_OPER) && ea_valid && !reg_wr)
            |=> $stable(areg_r);
    endproperty
    a_areg_hold: assert property (p_areg_hold)
        else $error("address register changed by a compare");

    property p_word_sext;
        @(posedge clk_sys) disable iff (reset)
        (exec_now && !kind_imm_r && (ea_r.size == SZ_WORD))
            |-> (op_src_r[31:16] == {16{op_src_r[15]}});
    endproperty
    a_word_sext: assert property (p_word_sext)
        else $error("word source not sign extended");

    property p_keep_x;
        @(posedge clk_sys) disable iff (reset)
        ((state_r == ST_OPER) && ea_valid && !reg_wr)
            |=> (ccr_r[CC_X] == $past(ccr_r[CC_X]));
    endproperty
    a_keep_x: assert property (p_keep_x)
        else $error("extend flag altered by compare");

    // Reference zero and borrow, worked out from the held operands.
    logic fu_chk_z;
    logic fu_chk_c;
    assign fu_chk_z = (op_sz_r == SZ_BYTE) ?
        (op_dst_r[7:0] == op_src_r[7:0]) :
        (op_sz_r == SZ_WORD) ? (op_dst_r[15:0] == op_src_r[15:0]) :
        (op_dst_r == op_src_r);
    assign fu_chk_c = (op_sz_r == SZ_BYTE) ?
        (op_src_r[7:0] > op_dst_r[7:0]) :
        (op_sz_r == SZ_WORD) ? (op_src_r[15:0] > op_dst_r[15:0]) :
        (op_src_r > op_dst_r);

    property p_flag_zc;
        @(posedge clk_sys) disable iff (reset)
        exec_now |-> (ccr_r[CC_Z] == (fu_chk_z)) &&
                     (ccr_r[CC_C] == fu_chk_c);
    endproperty
    a_flag_zc: assert property (p_flag_zc)
        else $error("zero or borrow flag wrong after compare");

    property p_opmode;
        @(posedge clk_sys) disable iff (reset)
        (accept && is_areg_cmp && (op_opmode != OPMODE_WORD) &&
         (op_opmode != OPMODE_LONG)) |=> illegal_r;
    endproperty
    a_opmode: assert property (p_opmode)
        else $error("bad opmode not refused");

    property p_dst_sel;
        @(posedge clk_sys) disable iff (reset)
        (accept && areg_ok) |=> (dst_idx_r == $past(op_word[11:9]));
    endproperty
    a_dst_sel: assert property (p_dst_sel)
        else $error("destination register not taken from opcode");

    property p_src_all;
        @(posedge clk_sys) disable iff (reset)
        (accept && is_areg_cmp && (op_opmode == OPMODE_LONG) &&
         (op_mode != EA_MODE_EXT)) |=> (state_r == ST_OPER) && ea_req;
    endproperty
    a_src_all: assert property (p_src_all)
        else $error("address compare source mode refused");

    property p_imm_size;
        @(posedge clk_sys) disable iff (reset)
        (state_r == ST_OPER) && kind_imm_r |->
            (ext_cnt_r == ((ea_r.size == SZ_LONG) ? 2'd2 : 2'd1));
    endproperty
    a_imm_size: assert property (p_imm_size)
        else $error("wrong number of immediate words");

    property p_size_bad;
        @(posedge clk_sys) disable iff (reset)
        (accept && is_imm_cmp && (op_size == SZ_BAD)) |=> illegal_r;
    endproperty
    a_size_bad: assert property (p_size_bad)
        else $error("size code 11 not refused");

    property p_no_areg_dst;
        @(posedge clk_sys) disable iff (reset)
        (accept && is_imm_cmp && (op_mode == EA_MODE_AREG))
            |=> illegal_r && (state_r == ST_IDLE);
    endproperty
    a_no_areg_dst: assert property (p_no_areg_dst)
        else $error("address register destination not refused");

    property p_recog;
        @(posedge clk_sys) disable iff (reset)
        (accept && !is_areg_cmp && !is_imm_cmp) |=> illegal_r ##1 !done_r;
    endproperty
    a_recog: assert property (p_recog)
        else $error("foreign opcode not refused");

    c_areg_word: cover property (@(posedge clk_sys) disable iff (reset)
        exec_now && !kind_imm_r && (ea_r.size == SZ_WORD));
    c_imm_long: cover property (@(posedge clk_sys) disable iff (reset)
        exec_now && kind_imm_r && (ea_r.size == SZ_LONG));
    c_illegal: cover property (@(posedge clk_sys) disable iff (reset)
        illegal_r);
endmodule
`default_nettype wire

// ---- verilog/cai_flag_unit.sv ----
`timescale 1ns/1ps
`default_nettype none
module cai_flag_unit
(
    input wire logic [31:0] dst,
    input wire logic [31:0] src,
    input wire cai_pkg::cai_size_type size,
    output logic [31:0] diff,
    output cai_pkg::cai_nzvc_type flags
);
    import cai_pkg::*;

    logic [2:0] n_s;
    logic [2:0] z_s;
    logic [2:0] v_s;
    logic [2:0] c_s;

    // ----------------------------------------------------------------
    // One subtractor per operand width
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : g_width
            localparam int W = 8 << g;
            logic [W:0] d;
            // Extra top bit of the difference is the borrow.
            assign d = {1'b0, dst[W-1:0]} - {1'b0, src[W-1:0]};
            assign n_s[g] = d[W-1];
            assign z_s[g] = (d[W-1:0] == '0);
            assign c_s[g] = d[W];
            assign v_s[g] = (dst[W-1] ^ src[W-1]) & (dst[W-1] ^ d[W-1]);
        end
    endgenerate

    // Pick the flags of the width that the size code names.
    always_comb
    begin
        diff = dst - src;
        case (size)
            SZ_BYTE:
            begin
                flags = '{n_s[0], z_s[0], v_s[0], c_s[0]};
            end
            SZ_WORD:
            begin
                flags = '{n_s[1], z_s[1], v_s[1], c_s[1]};
            end
            default:
            begin
                flags = '{n_s[2], z_s[2], v_s[2], c_s[2]};
            end
        endcase
    end
endmodule
`default_nettype wire
